// ===== hdl/asg_params.svh
// Constants for the host-side auto-save mode sequencer
// Operation
// [RULE_01] Steps one to three read fixed addresses
// [RULE_02] Steps four and five read fixed addresses
// [RULE_03] Sixth read 0x8b45 disables auto save
// [RULE_04] Sixth read 0x4b46 enables auto save
// [RULE_05] Every step is a chip-enable controlled read
// [RULE_06] Six reads consecutive, write strobe high
// [RULE_07] Host stores after changing auto-save state
// [RULE_08] Shipped with auto save enabled, cells zero
// [RULE_09] Low core supply blocks stores and writes
// [RULE_10] Write held at power-up is suppressed
// [RULE_11] Low I/O supply disables pins, no store
// [RULE_12] Intervening access aborts the mode sequence
// [RULE_13] Only address bits 14 to 2 compared
// [RULE_14] Tracker restarts after match or mismatch
// [RULE_15] Enable flag saved by store, reloaded by recall
`ifndef ASG_PARAMS_SVH
`define ASG_PARAMS_SVH

// ----------------------------------------------------------------
// Sequence addresses
// ----------------------------------------------------------------
`define ASG_ADDR_W        19
`define ASG_DATA_W        16
`define ASG_SEQ_A1        19'h04e38
`define ASG_SEQ_A2        19'h0b1c7
`define ASG_SEQ_A3        19'h083e0
`define ASG_SEQ_A4        19'h07c1f
`define ASG_SEQ_A5        19'h0703f
`define ASG_SEQ_DISABLE   19'h08b45
`define ASG_SEQ_ENABLE    19'h04b46
`define ASG_SEQ_STORE     19'h08fc0
`define ASG_SEQ_STEPS     3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ASG_CLK_PERIOD_PS 4000
// Read cycle time, least, in ns; rounds up to cycles
`define ASG_T_RC_NS       45
`define ASG_T_RC_CYC      ((`ASG_T_RC_NS * 1000 + `ASG_CLK_PERIOD_PS - 1) / `ASG_CLK_PERIOD_PS)
// Chip disable to outputs inactive, least gap between cycles, in ns
`define ASG_T_HZ_NS       15
`define ASG_T_HZ_CYC      ((`ASG_T_HZ_NS * 1000 + `ASG_CLK_PERIOD_PS - 1) / `ASG_CLK_PERIOD_PS)
`define ASG_CNT_W         5
// Reset value of the host's shadow of the auto-save flag
`define ASG_AUTO_SAVE_RST 1'b1

`endif

// ===== hdl/asg_pkg.sv
// Types for the host-side auto-save mode sequencer
package asg_pkg;

    typedef enum logic [1:0] {
        ASG_CMD_DISABLE,
        ASG_CMD_ENABLE,
        ASG_CMD_STORE
    } asg_cmd_t;

    typedef enum {
        ASG_IDLE,
        ASG_SETUP,
        ASG_STROBE,
        ASG_GAP,
        ASG_DONE
    } asg_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [18:0] addr;
    } asg_bus_t;

    typedef struct packed {
        asg_state_t  state;
        asg_cmd_t    cmd;
        logic [2:0]  step;
        logic [4:0]  cnt;
        asg_bus_t    bus;
        logic [15:0] last_data;
        logic        auto_save;
        logic        pending_store;
        logic        done;
        logic        aborted;
        logic        saved_auto_save;
        logic        quit;
    } asg_state_reg_t;

endpackage : asg_pkg

// ===== hdl/asg_addr_rom.sv
// Address lookup for each step of a mode sequence
`timescale 1ns/1ps
`include "asg_params.svh"

module asg_addr_rom
    import asg_pkg::*;
(
    input  wire asg_cmd_t    cmd,
    input  wire logic [2:0]  step,
    output logic [18:0]      addr
);

    // Only bits 14..2 matter to the device; bits 18..16 are left zero
    always_comb begin
        case (step)
            3'h0:    addr = `ASG_SEQ_A1; // RULE_01
            3'h1:    addr = `ASG_SEQ_A2; // RULE_01
            3'h2:    addr = `ASG_SEQ_A3; // RULE_01
            3'h3:    addr = `ASG_SEQ_A4; // RULE_02
            3'h4:    addr = `ASG_SEQ_A5; // RULE_02
            default: begin
                case (cmd)
                    ASG_CMD_DISABLE: addr = `ASG_SEQ_DISABLE; // RULE_03
                    ASG_CMD_ENABLE:  addr = `ASG_SEQ_ENABLE; // RULE_04
                    default:         addr = `ASG_SEQ_STORE; // RULE_07
                endcase
            end
        endcase
    end

endmodule : asg_addr_rom

// ===== hdl/asg_host_seq.sv
// Host controller that issues auto-save mode and store sequences
`timescale 1ns/1ps
`include "asg_params.svh"

// The write strobe never falls here, so a half-decoded mode sequence can
// never turn into an array write; the price is that this block cannot
// carry normal memory traffic and must own the bus while it runs
module asg_host_seq
    import asg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        req,
    input  wire asg_cmd_t    req_cmd,
    output logic             ready,
    output logic             done,
    output logic             aborted,
    output logic             auto_save,
    output logic             store_pending,
    output logic [15:0]      last_data,
    input  wire logic        core_power_ok,
    input  wire logic        io_power_ok,
    input  wire logic        hardware_store_busy_n,
    input  wire logic        recall_seen,
    output logic             mem_ce_n,
    output logic             mem_oe_n,
    output logic             mem_we_n,
    output logic [18:0]      mem_addr,
    input  wire logic [15:0] mem_dq_in
);

    asg_state_reg_t r;
    asg_state_reg_t next_r;
    logic [18:0]    step_addr;
    logic           link_ok;
    logic           strobe_end;
    logic           gap_end;
    logic           last_step;
    logic           busy;

    // ----------------------------------------------------------------
    // Step address lookup
    // ----------------------------------------------------------------
    // Fed from the registered state so the lookup is not part of a loop through next_r
    asg_addr_rom u_rom (
        .cmd  (r.cmd),
        .step (r.step),
        .addr (step_addr)
    );

    // ----------------------------------------------------------------
    // Link and timing conditions
    // ----------------------------------------------------------------
    // A sequence can only land while the device is powered and idle
    assign link_ok = core_power_ok && io_power_ok && hardware_store_busy_n; // RULE_09
    // Strobe stays low for at least one full read cycle time
    assign strobe_end = (r.cnt == 5'(`ASG_T_RC_CYC));
    // Outputs must go inactive before the next strobe may fall
    assign gap_end = (r.cnt == 5'(`ASG_T_HZ_CYC));
    assign last_step = (r.step == `ASG_SEQ_STEPS - 3'h1);
    // Anything but idle means reads are in flight or being closed
    assign busy = (r.state != ASG_IDLE);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.aborted = 1'b0;
        // Device reloads its flag from the stored copy on recall, and the
        // shadow then agrees with what a store would write
        if (recall_seen) begin
            next_r.auto_save = r.saved_auto_save; // RULE_15
            next_r.pending_store = 1'b0;
        end
        case (r.state)
            ASG_IDLE: begin
                // Strobes parked high so the device sees no access between requests
                next_r.bus.ce_n = 1'b1;
                next_r.bus.oe_n = 1'b1;
                next_r.bus.we_n = 1'b1; // RULE_06
                if (req && link_ok) begin
                    next_r.cmd = req_cmd;
                    next_r.step = 3'h0;
                    next_r.cnt = '0;
                    next_r.state = ASG_SETUP;
                end
            end
            ASG_SETUP: begin
                // Address settles before chip enable falls
                next_r.bus.addr = step_addr; // RULE_13
                next_r.state = ASG_STROBE;
            end
            ASG_STROBE: begin
                // Chip-enable delimits each read; output enable held low
                next_r.bus.ce_n = 1'b0; // RULE_05
                next_r.bus.oe_n = 1'b0;
                next_r.bus.we_n = 1'b1; // RULE_06
                next_r.cnt = r.cnt + 5'h1;
                if (!link_ok) begin
                    // Device ignores the sequence under low supply; give up cleanly
                    next_r.aborted = 1'b1; // RULE_11
                    next_r.bus.ce_n = 1'b1;
                    next_r.bus.oe_n = 1'b1;
                    // Still honour the bus turnaround before a new request may start
                    next_r.quit = 1'b1;
                    next_r.cnt = '0;
                    next_r.state = ASG_GAP;
                end else if (strobe_end) begin
                    // Data taken on the last strobe-low edge, when it has settled longest
                    next_r.last_data = mem_dq_in;
                    next_r.bus.ce_n = 1'b1;
                    next_r.bus.oe_n = 1'b1;
                    next_r.cnt = '0;
                    next_r.state = ASG_GAP;
                end
            end
            ASG_GAP: begin
                next_r.cnt = r.cnt + 5'h1;
                if (!link_ok && !r.quit && !last_step) begin
                    // Link lost between reads: the device would miss the rest anyway.
                    // The last gap is spared, as a store sequence makes the device busy.
                    next_r.aborted = 1'b1; // RULE_09
                    next_r.quit = 1'b1;
                    next_r.cnt = '0;
                end else if (gap_end) begin
                    next_r.cnt = '0;
                    // No other access is let in between steps
                    if (r.quit) begin
                        // Abandoned: the device tracker restarts on the first address
                        next_r.quit = 1'b0;
                        next_r.state = ASG_IDLE;
                    end else if (last_step) begin // RULE_12
                        next_r.state = ASG_DONE;
                    end else begin
                        next_r.step = r.step + 3'h1;
                        next_r.state = ASG_SETUP;
                    end
                end
            end
            ASG_DONE: begin
                next_r.done = 1'b1;
                case (r.cmd)
                    ASG_CMD_DISABLE: begin
                        next_r.auto_save = 1'b0; // RULE_03
                        next_r.pending_store = 1'b1; // RULE_07
                    end
                    ASG_CMD_ENABLE: begin
                        next_r.auto_save = 1'b1; // RULE_04
                        next_r.pending_store = 1'b1; // RULE_07
                    end
                    ASG_CMD_STORE: begin
                        // The flag as it stands now is what a later recall brings back
                        next_r.saved_auto_save = r.auto_save; // RULE_15
                        next_r.pending_store = 1'b0; // RULE_07
                    end
                    default: begin
                        // Unused command code: nothing the host tracks has changed
                        next_r.pending_store = r.pending_store;
                    end
                endcase
                next_r.state = ASG_IDLE;
            end
            default: begin
                next_r.state = ASG_IDLE;
            end
        endcase
        // A recall clears the array and stalls the device, so a half-sent
        // sequence is lost; close the strobe and let the gap run out first
        if (recall_seen && busy && !r.quit && (r.state != ASG_DONE)) begin
            next_r.aborted = 1'b1;
            next_r.bus.ce_n = 1'b1;
            next_r.bus.oe_n = 1'b1;
            next_r.quit = 1'b1;
            next_r.cnt = '0;
            next_r.state = ASG_GAP;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r.state <= ASG_IDLE;
            r.cmd <= ASG_CMD_DISABLE;
            r.step <= 3'h0;
            r.cnt <= '0;
            r.bus.ce_n <= 1'b1;
            r.bus.oe_n <= 1'b1;
            r.bus.we_n <= 1'b1;
            r.bus.addr <= '0;
            r.last_data <= '0;
            // Shadow and stored copy start as the part ships: auto save on
            r.auto_save <= `ASG_AUTO_SAVE_RST; // RULE_08
            r.saved_auto_save <= `ASG_AUTO_SAVE_RST; // RULE_08
            r.quit <= 1'b0;
            r.pending_store <= 1'b0;
            r.done <= 1'b0;
            r.aborted <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // A new request is only taken from idle with the link healthy
    assign ready = !busy && link_ok;
    assign done = r.done;
    assign aborted = r.aborted;
    assign auto_save = r.auto_save;
    assign store_pending = r.pending_store;
    assign last_data = r.last_data;
    assign mem_ce_n = r.bus.ce_n;
    assign mem_oe_n = r.bus.oe_n;
    assign mem_we_n = r.bus.we_n;
    assign mem_addr = r.bus.addr;

endmodule : asg_host_seq

// ===== testbench/asg_host_props.sv
// Port checker for the auto-save host sequencer
`timescale 1ns/1ps
module asg_host_props
    import asg_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        req,
    input wire asg_cmd_t    req_cmd,
    input wire logic        ready,
    input wire logic        done,
    input wire logic        aborted,
    input wire logic        auto_save,
    input wire logic        store_pending,
    input wire logic [15:0] last_data,
    input wire logic        core_power_ok,
    input wire logic        io_power_ok,
    input wire logic        hardware_store_busy_n,
    input wire logic        recall_seen,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic [18:0] mem_addr,
    input wire logic [15:0] mem_dq_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_we_idle: assert property (mem_we_n)
        else $error("write strobe low");
    chk_ce_oe: assert property (mem_ce_n == mem_oe_n)
        else $error("strobes split");
    chk_addr_hold: assert property (!mem_ce_n && !$past(mem_ce_n) |-> $stable(mem_addr))
        else $error("address moved");
    chk_gap_len: assert property ($rose(mem_ce_n) |-> mem_ce_n[*4])
        else $error("gap short");
    chk_ready_pwr: assert property (ready |-> core_power_ok && io_power_ok)
        else $error("ready in low power");
    chk_no_start: assert property (mem_ce_n && !core_power_ok |=> mem_ce_n)
        else $error("strobe in low power");
    chk_done_once: assert property (done |=> !done)
        else $error("done held");
    chk_flag_cause: assert property ($changed(auto_save) |-> done || $past(recall_seen))
        else $error("flag moved alone");
    chk_pend_rise: assert property ($rose(store_pending) |-> done)
        else $error("pending without done");
    cover property (done && !auto_save);
    cover property (aborted);
    cover property (done && !store_pending);
endmodule : asg_host_props

bind asg_host_seq asg_host_props u_props (.clk, .nrst, .req, .req_cmd, .ready, .done,
    .aborted, .auto_save, .store_pending, .last_data, .core_power_ok, .io_power_ok,
    .hardware_store_busy_n, .recall_seen, .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_addr,
    .mem_dq_in);

// ===== testbench/asg_dev_model.sv
// Behavioural model of the memory's mode decoder
`timescale 1ns/1ps
`include "asg_params.svh"
module asg_dev_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [18:0] addr,
    output logic [15:0]      dq,
    output logic             flag,
    output logic [7:0]       stores,
    output logic [7:0]       reads
);
    logic [18:0] seq [8] = '{`ASG_SEQ_A1, `ASG_SEQ_A2, `ASG_SEQ_A3, `ASG_SEQ_A4,
        `ASG_SEQ_A5, `ASG_SEQ_DISABLE, `ASG_SEQ_ENABLE, `ASG_SEQ_STORE};
    logic [2:0]  step;
    logic        ce_q;
    logic [12:0] a;
    assign a = addr[14:2];
    // Deselected bus toggles so a late sample cannot pass by luck
    assign dq = (!ce_n && !oe_n) ? addr[15:0] ^ 16'ha5a5 : {16{clk}};
    always_ff @(posedge clk) begin
        ce_q <= ce_n;
        if (!nrst) begin
            step <= 3'h0;
            flag <= 1'b1;
            stores <= 8'h00;
            reads <= 8'h00;
        end else if (!ce_q && ce_n && !we_n) begin
            step <= 3'h0;
        end else if (!ce_q && ce_n) begin
            reads <= reads + 8'h01;
            if (step == 3'h5) begin
                step <= 3'h0;
                if (a == seq[5][14:2]) flag <= 1'b0;
                if (a == seq[6][14:2]) flag <= 1'b1;
                if (a == seq[7][14:2]) stores <= stores + 8'h01;
            end else if (a == seq[step][14:2]) begin
                step <= step + 3'h1;
            end else begin
                step <= (a == seq[0][14:2]) ? 3'h1 : 3'h0;
            end
        end
    end
endmodule : asg_dev_model

// ===== testbench/tb_top.sv
// Self-checking bench for the auto-save host sequencer
`timescale 1ns/1ps
`include "asg_params.svh"
module tb_top
    import asg_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        req = 1'b0;
    asg_cmd_t    req_cmd = ASG_CMD_DISABLE;
    logic        core_power_ok = 1'b1;
    logic        io_power_ok = 1'b1;
    logic        hardware_store_busy_n = 1'b1;
    logic        recall_seen = 1'b0;
    logic        ready, done, aborted, auto_save, store_pending, flag;
    logic        mem_ce_n, mem_oe_n, mem_we_n;
    logic [15:0] last_data, mem_dq_in;
    logic [18:0] mem_addr;
    logic [7:0]  stores, reads, r0;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;
    always #2 clk = ~clk;
    asg_host_seq DUT (.clk, .nrst, .req, .req_cmd, .ready, .done, .aborted, .auto_save,
        .store_pending, .last_data, .core_power_ok, .io_power_ok, .hardware_store_busy_n,
        .recall_seen, .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_addr, .mem_dq_in);
    asg_dev_model u_dev (.clk, .nrst, .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .addr(mem_addr), .dq(mem_dq_in), .flag, .stores, .reads);
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic start(input asg_cmd_t c);
        n = 0;
        r0 = reads;
        while (ready !== 1'b1 && ++n < 100) @(negedge clk);
        @(posedge clk);
        req <= 1'b1;
        req_cmd <= c;
        @(posedge clk);
        req <= 1'b0;
    endtask : start
    task automatic sc_seq(input asg_cmd_t c, input logic [18:0] a6, input logic fl, pend);
        start(c);
        while (done !== 1'b1 && ++n < 400) @(negedge clk);
        check("done", done, 1'b1);
        check("reads", reads - r0, 19'h6);
        check("last_data", last_data, a6[15:0] ^ 16'ha5a5);
        check("auto_save", auto_save, fl);
        check("dev flag", flag, fl);
        check("pending", store_pending, pend);
    endtask : sc_seq
    task automatic sc_recall(input logic fl);
        @(posedge clk);
        recall_seen <= 1'b1;
        @(posedge clk);
        recall_seen <= 1'b0;
        @(negedge clk);
        check("auto_save", auto_save, fl);
        check("pending", store_pending, 1'b0);
    endtask : sc_recall
    task automatic sc_abort();
        start(ASG_CMD_DISABLE);
        while ((reads !== r0 + 8'h2 || mem_ce_n !== 1'b0) && ++n < 200) @(negedge clk);
        @(posedge clk);
        hardware_store_busy_n <= 1'b0;
        while (aborted !== 1'b1 && ++n < 300) @(negedge clk);
        check("aborted", aborted, 1'b1);
        @(posedge clk);
        hardware_store_busy_n <= 1'b1;
        repeat (8) @(negedge clk);
        check("dev flag", flag, 1'b1);
        check("auto_save", auto_save, 1'b1);
        check("pending", store_pending, 1'b1);
    endtask : sc_abort
    task automatic sc_power();
        for (int i = 0; i < 2; i++) begin
            r0 = reads;
            @(posedge clk);
            core_power_ok <= (i != 0);
            io_power_ok <= (i == 0);
            req <= 1'b1;
            repeat (40) @(negedge clk);
            check("ready", ready, 1'b0);
            check("reads", reads, r0);
            @(posedge clk);
            req <= 1'b0;
            core_power_ok <= 1'b1;
            io_power_ok <= 1'b1;
        end
    endtask : sc_power
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("auto_save", auto_save, 1'b1);
        check("ce_n", mem_ce_n, 1'b1);
        check("we_n", mem_we_n, 1'b1);
        sc_seq(ASG_CMD_DISABLE, `ASG_SEQ_DISABLE, 1'b0, 1'b1);
        sc_seq(ASG_CMD_STORE, `ASG_SEQ_STORE, 1'b0, 1'b0);
        check("stores", stores, 19'h1);
        sc_seq(ASG_CMD_ENABLE, `ASG_SEQ_ENABLE, 1'b1, 1'b1);
        sc_abort();
        sc_recall(1'b0);
        sc_power();
        conclude();
    end
endmodule : tb_top
